// *** core/exec_pkg.sv ***
// Shared constants and types for the instruction execution block.
// Assumes a single clock domain and a classic Wishbone register bus.
`default_nettype none

package exec_pkg;

	localparam int TCY_CLKS_DEF = 4;
	localparam int PC_W         = 13;
	localparam int K_W          = 11;
	localparam int F_W          = 7;
	localparam int D_W          = 8;
	localparam int PAGE_W       = 5;
	localparam int ADR_W        = 8;

	localparam logic [ADR_W-1:0] OFS_INSTR  = 8'h00;
	localparam logic [ADR_W-1:0] OFS_WORK   = 8'h04;
	localparam logic [ADR_W-1:0] OFS_STATUS = 8'h08;
	localparam logic [ADR_W-1:0] OFS_PC     = 8'h0C;
	localparam logic [ADR_W-1:0] OFS_PAGE   = 8'h10;
	localparam logic [ADR_W-1:0] OFS_STACK  = 8'h14;

	localparam int STAT_ZERO_BIT  = 0;
	localparam int STAT_PD_N_BIT  = 1;
	localparam int STAT_TO_N_BIT  = 2;
	localparam int STAT_BUSY_BIT  = 3;
	localparam int STAT_ILL_BIT   = 4;
	localparam int PAGE_HI_BIT    = 4;
	localparam int PAGE_LO_BIT    = 3;

	localparam logic [D_W-1:0]    CLEAR_VAL  = 8'h00;
	localparam logic [D_W-1:0]    WORK_RST   = 8'h00;
	localparam logic [PC_W-1:0]   PC_RST     = 13'h0000;
	localparam logic [PAGE_W-1:0] PAGE_RST   = 5'h00;
	localparam logic              ZERO_RST   = 1'b0;
	localparam logic              FLAG_N_RST = 1'b1;
	localparam logic              DEST_WORK  = 1'b0;
	localparam logic              DEST_FILE  = 1'b1;

	typedef enum logic [3:0] {
		OP_NOP    = 4'h0,
		OP_CALL   = 4'h1,
		OP_BRANCH = 4'h2,
		OP_CLEAR_FILE_REG   = 4'h3,
		OP_CLEAR_WORK_REG   = 4'h4,
		OP_WDCLR  = 4'h5,
		OP_COMPLEMENT_FILE_REG   = 4'h6,
		OP_DECREMENT_FILE_REG   = 4'h7,
		OP_DECSZ  = 4'h8
	} op_t;

	typedef struct packed {
		op_t            op;
		logic           dest;
		logic [K_W-1:0] arg;
	} instr_t;

	typedef struct packed {
		logic [D_W-1:0] value;
		logic           to_work;
		logic           to_file;
		logic           zero_upd;
		logic           zero;
		logic           skip;
		logic           legal;
	} fop_result_t;

endpackage

`default_nettype wire

// *** core/file_op_unit.sv ***
// Combinational result unit for the file and working register operations.
// Assumes the operand is the current content of the addressed file register.
`default_nettype none

module file_op_unit
	import exec_pkg::*;
(
	input  wire instr_t         instr_i,
	input  wire logic [D_W-1:0] operand_i,
	output fop_result_t         res_o
);

	wire logic [D_W-1:0] dec_val = operand_i - 8'h01;
	wire logic [D_W-1:0] com_val = ~operand_i;
	wire logic           to_f    = (instr_i.dest == DEST_FILE);

	always_comb begin
		res_o       = '0;
		res_o.legal = 1'b1;
		case (instr_i.op)
			OP_CLEAR_FILE_REG: begin
				res_o.value    = CLEAR_VAL;
				res_o.to_file  = 1'b1;
				res_o.zero_upd = 1'b1;
				res_o.zero     = 1'b1;
			end
			OP_CLEAR_WORK_REG: begin
				res_o.value    = CLEAR_VAL;
				res_o.to_work  = 1'b1;
				res_o.zero_upd = 1'b1;
				res_o.zero     = 1'b1;
			end
			OP_COMPLEMENT_FILE_REG, OP_DECREMENT_FILE_REG, OP_DECSZ: begin
				res_o.value    = (instr_i.op == OP_COMPLEMENT_FILE_REG) ? com_val : dec_val;
				res_o.to_file  = to_f;
				res_o.to_work  = !to_f;
				res_o.zero_upd = (instr_i.op != OP_DECSZ);
				res_o.zero     = (res_o.value == CLEAR_VAL);
				res_o.skip     = (instr_i.op == OP_DECSZ) && (dec_val == CLEAR_VAL);
			end
			OP_NOP, OP_CALL, OP_BRANCH, OP_WDCLR: begin
				res_o.legal = 1'b1;
			end
			default: begin
				res_o.legal = 1'b0;
			end
		endcase
	end

endmodule

`default_nettype wire

// *** core/call_clear_decrement_branch_exec.sv ***
// Executes call, clears, watchdog clear, complement, decrements and branch.
// Assumes a same-clock file register port, return stack and watchdog outside.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`default_nettype none

// Notes on behaviour
// RQ1: A call pushes program counter plus one onto the stack before redirecting.
// RQ2: A call loads counter bits 10..0 from the target, 12..11 from page bits 4..3.
// RQ3: A call takes two instruction cycles and leaves every status flag alone.
// RQ4: Clearing a file register writes zero there and always sets the zero flag.
// RQ5: Clearing the working register loads zero and sets only the zero flag.
// RQ6: Watchdog clear resets the watchdog count and its prescaler to zero.
// RQ7: Watchdog clear sets both active-low timeout and power-down flags to one.
// RQ8: Complement inverts the file register into the destination, updating only zero.
// RQ9: Destination bit zero selects the working register, one the file register.
// RQ10: Decrement subtracts one into the destination and updates only the zero flag.
// RQ11: Decrement-and-skip subtracts one into the destination and alters no flag.
// RQ12: A zero decrement result discards the next instruction, taking two cycles; the code skips for decrement-and-skip only.
// RQ13: A branch loads target and page bits into the counter and pushes nothing.
// RQ14: A branch takes two instruction cycles and leaves every status flag alone.
// RQ15: A computed zero flag is one exactly when the 8-bit result is zero.
module call_clear_decrement_branch_exec
	import exec_pkg::*;
#(
	parameter int TCY_CLKS = TCY_CLKS_DEF
)(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic              wb_we_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	output logic                   wb_ack_o,
	output logic      [F_W-1:0]    file_addr_o,
	input  wire logic [D_W-1:0]    file_rdata_i,
	output logic      [D_W-1:0]    file_wdata_o,
	output logic                   file_we_o,
	output logic                   stack_push_o,
	output logic      [PC_W-1:0]   stack_data_o,
	output logic                   wdt_clear_o,
	output logic                   busy_o
);

	generate
		if (TCY_CLKS < 1) begin : g_bad_tcy
			$error("TCY_CLKS must be at least one");
		end
	endgenerate

	typedef enum logic [3:0] {
		S_IDLE   = 4'b0001,
		S_ARM    = 4'b0010,
		S_EXEC   = 4'b0100,
		S_SECOND = 4'b1000
	} state_t;

	localparam int                CNT_W    = $clog2(TCY_CLKS + 1);
	localparam logic [CNT_W-1:0]  CNT_LAST = CNT_W'(TCY_CLKS - 1);

	function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs);
		hit = (adr[ADR_W-1:2] == ofs[ADR_W-1:2]);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
						input logic [3:0] sel);
		merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
	endfunction

	state_t              state_q;
	state_t              state_d;
	logic [CNT_W-1:0]    tcy_cnt_q;
	logic                ack_q;
	instr_t              instr_q;
	logic [D_W-1:0]      work_q;
	logic                zero_q;
	logic                to_n_q;
	logic                pd_n_q;
	logic                ill_q;
	logic [PC_W-1:0]     pc_q;
	logic [PC_W-1:0]     pc_d;
	logic [PAGE_W-1:0]   page_q;
	logic [PC_W-1:0]     stack_top_q;
	logic [D_W-1:0]      fwdata_q;
	logic                fwe_q;
	logic                push_q;
	logic                wdclr_q;
	logic [31:0]         rdata_q;
	fop_result_t         res;

	// Instruction cycle enable: every slower rate comes from this one pulse
	wire logic cycle_en = (tcy_cnt_q == CNT_LAST);

	always_ff @(posedge clk_i) begin
		if (rst_i || cycle_en) begin
			tcy_cnt_q <= '0;
		end else begin
			tcy_cnt_q <= tcy_cnt_q + 1'b1;
		end
	end

	// Bus: answer one cycle after the request, write takes effect with ack
	wire logic req      = wb_cyc_i && wb_stb_i;
	wire logic wr_fire  = req && wb_we_i && ack_q;
	wire logic wr_instr = wr_fire && hit(wb_adr_i, OFS_INSTR);
	wire logic wr_work  = wr_fire && hit(wb_adr_i, OFS_WORK) && wb_sel_i[0];
	wire logic wr_stat  = wr_fire && hit(wb_adr_i, OFS_STATUS) && wb_sel_i[0];
	wire logic wr_pc    = wr_fire && hit(wb_adr_i, OFS_PC);
	wire logic wr_page  = wr_fire && hit(wb_adr_i, OFS_PAGE) && wb_sel_i[0];
	wire logic idle     = (state_q == S_IDLE);
	wire logic commit   = (state_q == S_EXEC) && cycle_en;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && !ack_q;
		end
	end

	file_op_unit u_fop (
		.instr_i   (instr_q),
		.operand_i (file_rdata_i),
		.res_o     (res)
	);

	wire logic is_call   = (instr_q.op == OP_CALL);
	wire logic is_branch = (instr_q.op == OP_BRANCH);
	wire logic is_wdclr  = (instr_q.op == OP_WDCLR);
	wire logic two_cycle = is_call || is_branch || res.skip; // RQ3 RQ14 RQ12
	wire logic [PC_W-1:0] pc_inc  = pc_q + 13'h0001;
	wire logic [PC_W-1:0] pc_skip = pc_q + 13'h0002;
	wire logic [PC_W-1:0] pc_jump = {page_q[PAGE_HI_BIT:PAGE_LO_BIT], instr_q.arg}; // RQ2 RQ13

	always_comb begin
		pc_d = pc_inc;
		if (is_call || is_branch) begin
			pc_d = pc_jump; // RQ2 RQ13
		end else if (res.skip) begin
			pc_d = pc_skip; // RQ12
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (wr_instr) begin
					state_d = S_ARM;
				end
			end
			S_ARM: begin
				if (cycle_en) begin
					state_d = S_EXEC;
				end
			end
			S_EXEC: begin
				if (cycle_en) begin
					state_d = two_cycle ? S_SECOND : S_IDLE; // RQ3 RQ12 RQ14
				end
			end
			S_SECOND: begin
				if (cycle_en) begin
					state_d = S_IDLE;
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// A new instruction is accepted only while idle; later writes are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			instr_q <= '0;
		end else if (wr_instr && idle) begin
			instr_q <= instr_t'(merge16(16'(instr_q), wb_dat_i, wb_sel_i));
		end
	end

	// Execution wins over a bus write landing on the same edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			work_q <= WORK_RST;
		end else if (commit && res.to_work) begin
			work_q <= res.value; // RQ5 RQ9
		end else if (wr_work) begin
			work_q <= wb_dat_i[D_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zero_q <= ZERO_RST;
		end else if (commit && res.zero_upd) begin
			zero_q <= res.zero; // RQ4 RQ5 RQ8 RQ10 RQ15
		end else if (wr_stat) begin
			zero_q <= wb_dat_i[STAT_ZERO_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			to_n_q <= FLAG_N_RST;
			pd_n_q <= FLAG_N_RST;
		end else if (commit && is_wdclr) begin
			to_n_q <= 1'b1; // RQ7
			pd_n_q <= 1'b1; // RQ7
		end else if (wr_stat) begin
			to_n_q <= wb_dat_i[STAT_TO_N_BIT];
			pd_n_q <= wb_dat_i[STAT_PD_N_BIT];
		end
	end

	// Undefined opcode runs as a no-op; sticky, software writes one to clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ill_q <= 1'b0;
		end else if (commit && !res.legal) begin
			ill_q <= 1'b1;
		end else if (wr_stat && wb_dat_i[STAT_ILL_BIT]) begin
			ill_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_q <= PC_RST;
		end else if (commit) begin
			pc_q <= pc_d;
		end else if (wr_pc) begin
			pc_q <= PC_W'(merge16(16'(pc_q), wb_dat_i, wb_sel_i));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			page_q <= PAGE_RST;
		end else if (wr_page) begin
			page_q <= wb_dat_i[PAGE_W-1:0];
		end
	end

	// Return address is taken from the counter before it is redirected
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stack_top_q <= PC_RST;
			push_q      <= 1'b0;
		end else begin
			push_q <= commit && is_call; // RQ1 RQ13
			if (commit && is_call) begin
				stack_top_q <= pc_inc; // RQ1
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fwe_q    <= 1'b0;
			fwdata_q <= CLEAR_VAL;
			wdclr_q  <= 1'b0;
		end else begin
			fwe_q   <= commit && res.to_file; // RQ4 RQ9
			wdclr_q <= commit && is_wdclr; // RQ6
			if (commit && res.to_file) begin
				fwdata_q <= res.value; // RQ4 RQ8 RQ10 RQ11
			end
		end
	end

	wire logic [7:0] status_rd = {3'b000, ill_q, !idle, to_n_q, pd_n_q, zero_q};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= '0;
		end else if (req && !ack_q) begin
			rdata_q <= '0;
			if (hit(wb_adr_i, OFS_INSTR)) begin
				rdata_q <= {16'h0000, 16'(instr_q)};
			end else if (hit(wb_adr_i, OFS_WORK)) begin
				rdata_q <= {24'h00_0000, work_q};
			end else if (hit(wb_adr_i, OFS_STATUS)) begin
				rdata_q <= {24'h00_0000, status_rd};
			end else if (hit(wb_adr_i, OFS_PC)) begin
				rdata_q <= {19'h0_0000, pc_q};
			end else if (hit(wb_adr_i, OFS_PAGE)) begin
				rdata_q <= {27'h000_0000, page_q};
			end else if (hit(wb_adr_i, OFS_STACK)) begin
				rdata_q <= {19'h0_0000, stack_top_q};
			end
		end
	end

	assign wb_ack_o     = ack_q;
	assign wb_dat_o     = rdata_q;
	assign file_addr_o  = instr_q.arg[F_W-1:0];
	assign file_wdata_o = fwdata_q;
	assign file_we_o    = fwe_q;
	assign stack_push_o = push_q;
	assign stack_data_o = stack_top_q;
	assign wdt_clear_o  = wdclr_q; // RQ6
	assign busy_o       = !idle;

endmodule

`default_nettype wire

// *** test/call_clear_decrement_branch_exec_sva.sv ***
// Checker for the execution block, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none

module exec_sva
	import exec_pkg::*;
#(
	parameter int TCY_CLKS = TCY_CLKS_DEF
)(
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [31:0]      wb_dat_i,
	input wire logic [31:0]      wb_dat_o,
	input wire logic [3:0]       wb_sel_i,
	input wire logic             wb_we_i,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_ack_o,
	input wire logic [F_W-1:0]   file_addr_o,
	input wire logic [D_W-1:0]   file_rdata_i,
	input wire logic [D_W-1:0]   file_wdata_o,
	input wire logic             file_we_o,
	input wire logic             stack_push_o,
	input wire logic [PC_W-1:0]  stack_data_o,
	input wire logic             wdt_clear_o,
	input wire logic             busy_o
);
	op_t  op_q;
	logic dest_q;
	// Only writes taken while idle start an instruction
	wire  instr_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && !busy_o
		&& wb_adr_i[7:2] == OFS_INSTR[7:2];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_q <= OP_NOP;
			dest_q <= DEST_WORK;
		end else if (instr_wr) begin
			op_q <= op_t'(wb_dat_i[15:12]);
			dest_q <= wb_dat_i[11];
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_push_call; stack_push_o |-> op_q == OP_CALL; endproperty
	property p_push_busy; stack_push_o |-> busy_o ##1 (busy_o || TCY_CLKS < 2); endproperty
	property p_wdt; wdt_clear_o |-> op_q == OP_WDCLR ##1 !wdt_clear_o; endproperty
	property p_dest; file_we_o |-> op_q == OP_CLEAR_FILE_REG || dest_q == DEST_FILE; endproperty
	property p_clear_file_reg; file_we_o && op_q == OP_CLEAR_FILE_REG |-> file_wdata_o == CLEAR_VAL; endproperty
	property p_complement_file_reg;
		file_we_o && op_q == OP_COMPLEMENT_FILE_REG |-> file_wdata_o == ~$past(file_rdata_i);
	endproperty
	property p_dec;
		file_we_o && (op_q == OP_DECREMENT_FILE_REG || op_q == OP_DECSZ)
			|-> file_wdata_o == $past(file_rdata_i) - 8'h01;
	endproperty
	property p_skip;
		file_we_o && op_q == OP_DECSZ |-> busy_o == (file_wdata_o == CLEAR_VAL);
	endproperty
	property p_ack; $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o; endproperty

	a_push_call: assert property (p_push_call) else $error("push without call");
	a_push_busy: assert property (p_push_busy) else $error("call ended early");
	a_wdt: assert property (p_wdt) else $error("bad watchdog clear");
	a_dest: assert property (p_dest) else $error("file written for work dest");
	a_clear_file_reg: assert property (p_clear_file_reg) else $error("clear wrote nonzero");
	a_complement_file_reg: assert property (p_complement_file_reg) else $error("complement wrong");
	a_dec: assert property (p_dec) else $error("decrement wrong");
	a_skip: assert property (p_skip) else $error("skip cycle wrong");
	a_ack: assert property (p_ack) else $error("bus ack timing");

	c_push: cover property (stack_push_o);
	c_wdt: cover property (wdt_clear_o);
	c_skip: cover property (file_we_o && op_q == OP_DECSZ && busy_o);
endmodule

bind call_clear_decrement_branch_exec exec_sva #(.TCY_CLKS(TCY_CLKS)) u_sva (
	.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .file_addr_o(file_addr_o),
	.file_rdata_i(file_rdata_i), .file_wdata_o(file_wdata_o), .file_we_o(file_we_o),
	.stack_push_o(stack_push_o), .stack_data_o(stack_data_o),
	.wdt_clear_o(wdt_clear_o), .busy_o(busy_o));

`default_nettype wire

// *** test/call_clear_decrement_branch_exec_tb.sv ***
// Testbench for the execution block over its Wishbone registers.
// Assumes the file register read is combinational from a local array.
`default_nettype none

module call_clear_decrement_branch_exec_tb
	import exec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic file_we_o, stack_push_o, wdt_clear_o, busy_o;
	logic [ADR_W-1:0] wb_adr_i;
	logic [31:0]      wb_dat_i, wb_dat_o;
	logic [3:0]       wb_sel_i;
	logic [F_W-1:0]   file_addr_o;
	logic [D_W-1:0]   file_rdata_i, file_wdata_o;
	logic [PC_W-1:0]  stack_data_o;
	logic [D_W-1:0]   mem [128];
	int               err_total, n_compared, n_wdt;

	call_clear_decrement_branch_exec #(.TCY_CLKS(4)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
		.file_addr_o(file_addr_o), .file_rdata_i(file_rdata_i),
		.file_wdata_o(file_wdata_o), .file_we_o(file_we_o),
		.stack_push_o(stack_push_o), .stack_data_o(stack_data_o),
		.wdt_clear_o(wdt_clear_o), .busy_o(busy_o));

	assign file_rdata_i = mem[file_addr_o];

	always @(posedge clk_i) begin
		if (file_we_o === 1'b1) mem[file_addr_o] <= file_wdata_o;
		if (wdt_clear_o === 1'b1) n_wdt <= n_wdt + 1;
	end

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(a, 1'b1, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(a, 1'b0, 32'h0000_0000, q);
		chk(q, e);
	endtask

	// Presets operand, WORK and STATUS, runs one instruction, checks WORK, STATUS, the file register and PC
	task automatic run(input logic [15:0] ins, input logic [7:0] fv, input logic [31:0] st0,
			input logic [7:0] em, input logic [7:0] ew, input logic [31:0] es,
			input logic ab, input logic [12:0] ed);
		logic [31:0] pc0, q;
		mem[ins[6:0]] = fv;
		wr(OFS_WORK, 32'h0000_00AA);
		wr(OFS_STATUS, st0);
		wb(OFS_PC, 1'b0, 32'h0000_0000, pc0);
		wr(OFS_INSTR, 32'(ins));
		do wb(OFS_STATUS, 1'b0, 32'h0000_0000, q); while (q[STAT_BUSY_BIT] !== 1'b0);
		rd_chk(OFS_WORK, 32'(ew));
		rd_chk(OFS_STATUS, es);
		chk(32'(mem[ins[6:0]]), 32'(em));
		rd_chk(OFS_PC, ab ? 32'(ed) : pc0 + 32'(ed));
		$display("test %h done", ins);
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		close_out;
	end

	initial begin
		rst_i = 1'b1;
		{wb_we_i, wb_cyc_i, wb_stb_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0000_0000;
		wb_sel_i = 4'hF;
		{err_total, n_compared, n_wdt} = 0;
		foreach (mem[i]) mem[i] = 8'h00;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(OFS_STATUS, 32'h0000_0006);
		rd_chk(8'h18, 32'h0000_0000);
		wr(OFS_PC, 32'h0000_0123);
		wr(OFS_PAGE, 32'h0000_0018);
		run(16'h17FF, 8'h00, 32'h7, 8'h00, 8'hAA, 32'h7, 1'b1, 13'h1FFF);
		rd_chk(OFS_STACK, 32'h0000_0124);
		chk(32'(stack_data_o), 32'h0000_0124);
		wr(OFS_PAGE, 32'h0000_0008);
		run(16'h2005, 8'h00, 32'h6, 8'h00, 8'hAA, 32'h6, 1'b1, 13'h0805);
		rd_chk(OFS_STACK, 32'h0000_0124);
		run(16'h3010, 8'h55, 32'h6, 8'h00, 8'hAA, 32'h7, 1'b0, 13'h1);
		run(16'h4000, 8'h33, 32'h6, 8'h33, 8'h00, 32'h7, 1'b0, 13'h1);
		run(16'h5000, 8'h33, 32'h1, 8'h33, 8'hAA, 32'h7, 1'b0, 13'h1);
		chk(32'(n_wdt), 32'h0000_0001);
		run(16'h6020, 8'hFF, 32'h6, 8'hFF, 8'h00, 32'h7, 1'b0, 13'h1);
		run(16'h6820, 8'h0F, 32'h7, 8'hF0, 8'hAA, 32'h6, 1'b0, 13'h1);
		run(16'h7821, 8'h01, 32'h6, 8'h00, 8'hAA, 32'h7, 1'b0, 13'h1);
		run(16'h7021, 8'h00, 32'h7, 8'h00, 8'hFF, 32'h6, 1'b0, 13'h1);
		run(16'h8822, 8'h01, 32'h6, 8'h00, 8'hAA, 32'h6, 1'b0, 13'h2);
		run(16'h8022, 8'h05, 32'h7, 8'h05, 8'h04, 32'h7, 1'b0, 13'h1);
		// Undefined opcode runs as a no-op and raises the sticky illegal bit
		run(16'h9000, 8'h00, 32'h6, 8'h00, 8'hAA, 32'h16, 1'b0, 13'h1);
		wr(OFS_STATUS, 32'h0000_0016);
		rd_chk(OFS_STATUS, 32'h0000_0006);
		close_out;
	end
endmodule

`default_nettype wire
